/* src/pwc_pkg.sv */
/*
 * Constants for the single PWM channel core: register offsets, field
 * positions and reset values.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package pwc_pkg;
   // ==========================================================
   // Widths
   localparam int          PWC_CNT_W    = 8;
   localparam int          PWC_ADR_W    = 4;
   // ==========================================================
   // Register byte offsets
   localparam logic [3:0]  PWC_CTRL_OFF = 4'h0;
   localparam logic [3:0]  PWC_PER_OFF  = 4'h4;
   localparam logic [3:0]  PWC_DUTY_OFF = 4'h8;
   localparam logic [3:0]  PWC_CNT_OFF  = 4'hC;
   // ==========================================================
   // Control register fields
   localparam int          PWC_EN_BIT   = 0;
   localparam int          PWC_POL_BIT  = 1;
   localparam int          PWC_CAE_BIT  = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  PWC_PER_RST  = 8'hFF;
   localparam logic [7:0]  PWC_DUTY_RST = 8'h00;
   localparam logic [7:0]  PWC_CNT_RST  = 8'h00;
endpackage

/* src/pwc_channel.sv */
/*
 * One 8-bit PWM channel with double-buffered period and duty, polarity,
 * left/centre alignment and a Wishbone classic register slave.
 * Assumes clk_i at 50 MHz, a synchronous active-high reset and a one-cycle
 * clock-source enable pulse (src_tick_i) from an external prescaler on clk_i.
 */
// What this block does
// [RQ1] The counting logic sees source ticks only while the channel enable bit is high; the code gates them with gate_reg, one clock behind it.
// [RQ2] Changes of the enable take effect only on a clock edge through a registered gate.
// [RQ3] With the enable low the counter holds its value and does not count.
// [RQ4] With polarity one the output starts each cycle high and drops at the duty count.
// [RQ5] With polarity zero the output starts each cycle low and rises at the duty count.
// [RQ6] While enabled, new period and duty wait in buffers until period end, counter write or disable.
// [RQ7] Any counter write clears the counter and loads the buffered period and duty at once.
// [RQ8] While disabled, period and duty writes go to the buffer and the active latch together.
// [RQ9] Software can read the present counter value.
// [RQ10] The channel owns an 8-bit up/down counter stepped at the selected source rate.
// [RQ11] A counter match with the active duty toggles the output flip-flop.
// [RQ12] A period match acts according to the left or centre alignment mode.
// [RQ13] Left-aligned, a period match clears the counter, restores the start level and ends the period.
// [RQ14] Centre-aligned, the counter runs up to period then down to zero, where the period ends.
`timescale 1ns/1ps
module pwc_channel
#(
   parameter int CW = pwc_pkg::PWC_CNT_W
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          src_tick_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [pwc_pkg::PWC_ADR_W-1:0] adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   output logic                               pwm_o
);
   import pwc_pkg::*;

   // ==========================================================
   // Register storage
   logic          channel_enable_bit;
   logic          channel_polarity_bits;
   logic          centre_mode_reg;
   logic [CW-1:0] per_buf_reg;
   logic [CW-1:0] duty_buf_reg;
   logic [CW-1:0] per_act_reg;
   logic [CW-1:0] duty_act_reg;
   logic [CW-1:0] cnt_reg;
   logic          down_reg;
   logic          ff_reg;
   logic          gate_reg;
   logic          ack_reg;
   logic          req;
   logic          wr;
   logic          wr_ctrl;
   logic          wr_per;
   logic          wr_duty;
   logic          wr_cnt;
   logic          step;
   logic          per_end;
   logic          disable_edge;
   logic          duty_hit;

   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr  = req & we_i & sel_i[0];

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   // Count after one source tick; the duty compare looks one step ahead
   function automatic logic [CW-1:0] next_count(input logic [CW-1:0] c,
                                                input logic          centre,
                                                input logic          down,
                                                input logic          wrap);
      if (!centre && wrap) begin
         next_count = '0;
      end else if (centre && down) begin
         next_count = (c == '0) ? c : c - 1'b1;
      end else begin
         next_count = c + 1'b1;
      end
   endfunction

   assign wr_ctrl = wr & hit(adr_i, PWC_CTRL_OFF);
   assign wr_per  = wr & hit(adr_i, PWC_PER_OFF);
   assign wr_duty = wr & hit(adr_i, PWC_DUTY_OFF);
   assign wr_cnt  = wr & hit(adr_i, PWC_CNT_OFF);

   // ==========================================================
   // Wishbone slave: one wait state, ack for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end
   assign ack_o = ack_reg;

   // Unmapped offsets read zero and ignore writes, but still ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !we_i) begin
         unique case (1'b1)
            hit(adr_i, PWC_CTRL_OFF): dat_o <= {29'h0, centre_mode_reg,
                                                channel_polarity_bits, channel_enable_bit};
            hit(adr_i, PWC_PER_OFF):  dat_o <= {24'h0, per_buf_reg};
            hit(adr_i, PWC_DUTY_OFF): dat_o <= {24'h0, duty_buf_reg};
            hit(adr_i, PWC_CNT_OFF):  dat_o <= {24'h0, cnt_reg}; // see [RQ9]
            default:                  dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Control bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_enable_bit    <= 1'b0;
         channel_polarity_bits <= 1'b0;
         centre_mode_reg       <= 1'b0;
      end else if (wr_ctrl) begin
         channel_enable_bit    <= dat_i[PWC_EN_BIT];
         channel_polarity_bits <= dat_i[PWC_POL_BIT];
         centre_mode_reg       <= dat_i[PWC_CAE_BIT];
      end
   end

   // Registered gate: enable changes only reach the counter on an edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_reg <= 1'b0;
      end else begin
         gate_reg <= channel_enable_bit; // see [RQ2]
      end
   end

   assign step         = gate_reg & src_tick_i; // see [RQ1] see [RQ3]
   assign disable_edge = gate_reg & ~channel_enable_bit;
   // Left mode: period match; centre mode: back at zero while counting down
   assign per_end = step & (centre_mode_reg ? (down_reg && cnt_reg <= CW'(1))
                                            : (cnt_reg >= per_act_reg)); // see [RQ12]
   // Toggle as the counter arrives at the duty value, so the duty register
   // counts whole ticks of the first level rather than one tick too many
   assign duty_hit = step
                   & (next_count(cnt_reg, centre_mode_reg, down_reg, per_end) == duty_act_reg);

   // ==========================================================
   // Period and duty buffers and active latches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_buf_reg  <= PWC_PER_RST;
         duty_buf_reg <= PWC_DUTY_RST;
      end else begin
         if (wr_per) begin
            per_buf_reg <= dat_i[CW-1:0];
         end
         if (wr_duty) begin
            duty_buf_reg <= dat_i[CW-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_act_reg  <= PWC_PER_RST;
         duty_act_reg <= PWC_DUTY_RST;
      end else if (!gate_reg) begin
         // Disabled: writes pass straight through
         if (wr_per) begin
            per_act_reg <= dat_i[CW-1:0]; // see [RQ8]
         end else begin
            per_act_reg <= per_buf_reg;
         end
         if (wr_duty) begin
            duty_act_reg <= dat_i[CW-1:0]; // see [RQ8]
         end else begin
            duty_act_reg <= duty_buf_reg;
         end
      end else if (per_end || wr_cnt || disable_edge) begin
         per_act_reg  <= per_buf_reg; // see [RQ6] see [RQ7]
         duty_act_reg <= duty_buf_reg;
      end
   end

   // ==========================================================
   // Counter and output flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= PWC_CNT_RST;
         down_reg <= 1'b0;
      end else if (wr_cnt) begin
         cnt_reg  <= PWC_CNT_RST; // see [RQ7]
         down_reg <= 1'b0;
      end else if (step) begin // see [RQ10]
         if (!centre_mode_reg) begin
            down_reg <= 1'b0;
            if (per_end) begin
               cnt_reg <= PWC_CNT_RST; // see [RQ13]
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end else if (!down_reg) begin
            if (cnt_reg + 1'b1 >= per_act_reg) begin
               down_reg <= 1'b1; // see [RQ14]
            end
            cnt_reg <= cnt_reg + 1'b1;
         end else begin
            if (cnt_reg <= CW'(1)) begin
               down_reg <= 1'b0;
            end
            cnt_reg <= (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
         end
      end
   end

   // ff_reg high = output at its start level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ff_reg <= 1'b1;
      end else if (wr_cnt || per_end || !gate_reg) begin
         ff_reg <= 1'b1; // see [RQ13] see [RQ14]
      end else if (duty_hit) begin
         ff_reg <= ~ff_reg; // see [RQ11]
      end
   end

   // Polarity selects Q or Q-bar of the output flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_o <= 1'b0;
      end else begin
         pwm_o <= channel_polarity_bits ? ff_reg : ~ff_reg; // see [RQ4] see [RQ5]
      end
   end

   // ==========================================================
   // Assertions
   sequence s_en_off_two;
      !channel_enable_bit ##1 (!channel_enable_bit && !wr_cnt);
   endsequence

   sequence s_duty_hit;
      duty_hit && !per_end && !wr_cnt;
   endsequence

   sequence s_cnt_read;
      (cyc_i && stb_i && !ack_o && !we_i && adr_i == PWC_CNT_OFF) ##1 ack_o;
   endsequence

   a_gate_follows_en: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ2]
      gate_reg == $past(channel_enable_bit))
      else $error("gate does not follow enable by one edge");

   a_cnt_hold_off: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ3]
      (!gate_reg && !wr_cnt) |=> $stable(cnt_reg))
      else $error("counter moved while disabled");

   a_cnt_write_clr: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ7]
      wr_cnt |=> (cnt_reg == 8'h00 && per_act_reg == $past(per_buf_reg)))
      else $error("counter write did not clear and latch");

   a_off_direct: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ8]
      (wr_per && !gate_reg) |=> per_act_reg == $past(dat_i[7:0]))
      else $error("disabled period write not direct");

   a_buffer_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ6]
      (gate_reg && !per_end && !wr_cnt && channel_enable_bit) |=> $stable(per_act_reg))
      else $error("active period changed mid-cycle");

   a_pol_high: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ4]
      (channel_polarity_bits && $past(channel_polarity_bits) && $past(wr_cnt))
      |-> ##1 pwm_o)
      else $error("polarity one does not start high");

   a_pol_low: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ5]
      (!channel_polarity_bits && $past(channel_polarity_bits) == 1'b0 && $past(wr_cnt))
      |-> ##1 !pwm_o)
      else $error("polarity zero does not start low");

   a_duty_toggle: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ11]
      s_duty_hit |=> ff_reg != $past(ff_reg))
      else $error("duty match did not toggle");

   a_left_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ13]
      (per_end && !centre_mode_reg && !wr_cnt) |=> cnt_reg == 8'h00)
      else $error("left period match did not clear counter");

   a_count_step: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ10]
      (step && !centre_mode_reg && !per_end && !wr_cnt) |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("counter did not advance");

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ9]
      ack_o |=> !ack_o)
      else $error("ack longer than one cycle");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ9]
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not answered after one wait state");

   a_cnt_read: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ9]
      s_cnt_read |-> dat_o == {24'h0, $past(cnt_reg)})
      else $error("counter read returned a wrong value");

   a_en_gates_cnt: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ1]
      s_en_off_two |=> $stable(cnt_reg))
      else $error("counter moved with enable low");

   a_period_reload: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ6]
      (gate_reg && channel_enable_bit && per_end && !wr_cnt)
      |=> (per_act_reg == $past(per_buf_reg) && duty_act_reg == $past(duty_buf_reg)))
      else $error("buffers not latched at period end");

   a_duty_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ6]
      (gate_reg && !per_end && !wr_cnt && channel_enable_bit) |=> $stable(duty_act_reg))
      else $error("active duty changed mid-cycle");

   a_left_period: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ12]
      (step && !centre_mode_reg && cnt_reg == per_act_reg && !wr_cnt)
      |=> (cnt_reg == 8'h00 && ff_reg))
      else $error("left period match did not restart the waveform");

   a_centre_top: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ12]
      (step && centre_mode_reg && !down_reg) |-> !per_end)
      else $error("centre period ended while counting up");

   a_centre_up: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ14]
      (step && centre_mode_reg && !down_reg && !wr_cnt) |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("centre counter did not count up");

   a_centre_down: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ14]
      (step && centre_mode_reg && down_reg && cnt_reg != 8'h00 && !wr_cnt)
      |=> cnt_reg == $past(cnt_reg) - 8'h01)
      else $error("centre counter did not count down");

   a_centre_end: assert property (@(posedge clk_i) disable iff (rst_i) // see [RQ14]
      (step && centre_mode_reg && down_reg && cnt_reg == 8'h01 && !wr_cnt)
      |=> (cnt_reg == 8'h00 && !down_reg && ff_reg))
      else $error("centre period did not end at zero");
endmodule

/* dv/tb_top.sv */
/*
 * Self-checking bench for the PWM channel core: Wishbone register access,
 * reset values, gating, buffering and waveform shape in both alignments.
 * Assumes the pwc_channel ports and pwc_pkg offsets as declared in src/.
 */
`timescale 1ns/1ps
module tb_top;
   import pwc_pkg::*;
   // ==========================================================
   // Stimulus and design
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        src_tick_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        pwm_o;
   int          error_cnt = 0;
   int          checked = 0;

   always #10 clk_i = ~clk_i;

   pwc_channel dut (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .src_tick_i (src_tick_i),
      .cyc_i      (cyc_i),
      .stb_i      (stb_i),
      .we_i       (we_i),
      .adr_i      (adr_i),
      .sel_i      (sel_i),
      .dat_i      (dat_i),
      .dat_o      (dat_o),
      .ack_o      (ack_o),
      .pwm_o      (pwm_o)
   );

   // ==========================================================
   // Checking and bus tasks
   task automatic conclude;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   // Holds the request until ack is sampled, then leaves one idle cycle
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                     input logic [3:0] sel, output logic [31:0] rd);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= we;
      adr_i <= adr;
      dat_i <= wd;
      sel_i <= sel;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         conclude();
      end
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] adr, input logic [7:0] d);
      logic [31:0] rd;
      wb(1'b1, adr, {24'h0, d}, 4'hF, rd);
   endtask

   task automatic rdchk(input string name, input logic [3:0] adr, input logic [7:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0, 4'hF, rd);
      chk(name, {24'h0, exp}, rd);
   endtask

   // Periodic signal: over whole periods the counts do not depend on phase
   task automatic meas(input string name, input int n, input int hi, input int rise);
      int h;
      int r;
      logic p;
      h = 0;
      r = 0;
      p = pwm_o;
      repeat (20) @(posedge clk_i);
      p = pwm_o;
      repeat (n) begin
         @(posedge clk_i);
         h += (pwm_o === 1'b1);
         r += (pwm_o === 1'b1 && p === 1'b0);
         p = pwm_o;
      end
      chk({name, " high"}, hi, h);
      chk({name, " rises"}, rise, r);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] a;
      logic [31:0] b;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("pwm idle", 32'h0, {31'h0, pwm_o});
      rdchk("ctrl", PWC_CTRL_OFF, 8'h00);
      rdchk("period", PWC_PER_OFF, PWC_PER_RST);
      rdchk("duty", PWC_DUTY_OFF, PWC_DUTY_RST);
      rdchk("unmapped", 4'h2, 8'h00);
      repeat (5) @(posedge clk_i);
      rdchk("count off", PWC_CNT_OFF, PWC_CNT_RST);
      wr(PWC_PER_OFF, 8'h09);
      wr(PWC_DUTY_OFF, 8'h03);
      wb(1'b1, PWC_PER_OFF, 32'h55, 4'hE, a);
      rdchk("sel ignored", PWC_PER_OFF, 8'h09);
      wr(PWC_CTRL_OFF, 8'h03);
      meas("left pol1", 50, 15, 5);
      wr(PWC_CTRL_OFF, 8'h01);
      meas("left pol0", 50, 35, 5);
      src_tick_i <= 1'b0;
      wr(PWC_DUTY_OFF, 8'h06);
      rdchk("duty buffer", PWC_DUTY_OFF, 8'h06);
      wr(PWC_CNT_OFF, 8'h5A);
      rdchk("count cleared", PWC_CNT_OFF, 8'h00);
      chk("start level", 32'h0, {31'h0, pwm_o});
      src_tick_i <= 1'b1;
      meas("new duty", 50, 20, 5);
      wr(PWC_CTRL_OFF, 8'h00);
      wb(1'b0, PWC_CNT_OFF, 32'h0, 4'hF, a);
      repeat (6) @(posedge clk_i);
      wb(1'b0, PWC_CNT_OFF, 32'h0, 4'hF, b);
      chk("count held", a, b);
      wr(PWC_PER_OFF, 8'h08);
      wr(PWC_DUTY_OFF, 8'h02);
      wr(PWC_CTRL_OFF, 8'h07);
      meas("centre pol1", 64, 16, 4);
      wr(PWC_CNT_OFF, 8'h00);
      chk("start high", 32'h1, {31'h0, pwm_o});
      conclude();
   end
endmodule
